// ==== bcsr_pkg.sv ====
/*
 * Shared constants, carriers and helpers for the boot cluster swap remap.
 * Assumes a 16-bit CPU address space with the two boot clusters at its bottom.
 */
`default_nettype none

package bcsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // address map
    localparam int ADDR_W = 16;
    // a boot cluster is 4 KB, so address bit 12 selects cluster 0 or 1
    localparam int CLUSTER_BITS = 12;
    localparam logic [ADDR_W-1:0] CLUSTER0_BASE = 16'h0000;
    localparam logic [ADDR_W-1:0] CLUSTER0_LAST = 16'h0fff;
    localparam logic [ADDR_W-1:0] CLUSTER1_BASE = 16'h1000;
    localparam logic [ADDR_W-1:0] CLUSTER1_LAST = 16'h1fff;
    // first address above the swappable window
    localparam logic [ADDR_W-1:0] SWAP_LIMIT = 16'h2000;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic SWAP_RST = 1'b0;
    localparam logic READY_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // carriers and states
    typedef struct packed {
        logic valid;
        logic is_fetch;
        logic [ADDR_W-1:0] addr;
    } bcsr_acc_t;

    typedef enum logic {
        BCSR_LOAD,
        BCSR_RUN
    } bcsr_boot_t;

    typedef enum logic {
        BCSR_SVC_IDLE,
        BCSR_SVC_PROG
    } bcsr_svc_t;

    ////////////////////////////////////////////////////////////////////////////
    // exchange the two boot clusters by flipping the cluster select bit
    function automatic logic [ADDR_W-1:0] bcsr_remap_f(
        input logic [ADDR_W-1:0] addr,
        input logic swap
    );
        logic [ADDR_W-1:0] res;
        res = addr;
        if (swap && (addr < SWAP_LIMIT))
        begin
            res[CLUSTER_BITS] = ~addr[CLUSTER_BITS];
        end
        return res;
    endfunction

endpackage

`default_nettype wire

// ==== bcsr_flag_svc.sv ====
/*
 * Set-information service for the persistent boot swap flag.
 * Assumes a nonvolatile bit store that acknowledges each program request
 * with nv_wr_ack held or pulsed while nv_wr_req is high.
 */
`timescale 1ns/100ps
`default_nettype none

module bcsr_flag_svc (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic svc_req,
    input wire logic svc_swap,
    input wire logic nv_wr_ack,
    output var logic nv_wr_req,
    output var logic nv_wr_val,
    output var logic svc_busy,
    output var logic svc_done
);
    import bcsr_pkg::*;

    bcsr_svc_t state_q;
    logic req_q;
    logic val_q;
    logic done_q;

    ////////////////////////////////////////////////////////////////////////////
    // request handshake; a call made while busy is dropped, callers watch svc_busy
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= BCSR_SVC_IDLE;
            req_q <= 1'b0;
            val_q <= SWAP_RST;
        end
        else
        begin
            unique case (state_q)
                BCSR_SVC_IDLE:
                begin
                    if (svc_req)
                    begin
                        state_q <= BCSR_SVC_PROG;
                        req_q <= 1'b1;
                        val_q <= svc_swap;
                    end
                end
                BCSR_SVC_PROG:
                begin
                    if (nv_wr_ack)
                    begin
                        state_q <= BCSR_SVC_IDLE;
                        req_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // completion pulse, one cycle after the store acknowledges
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= (state_q == BCSR_SVC_PROG) && nv_wr_ack;
        end
    end

    assign nv_wr_req = req_q;
    assign nv_wr_val = val_q;
    assign svc_busy = req_q;
    assign svc_done = done_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    svc_write_start_a: assert property (@(posedge mclk) disable iff (!nrst)
        (svc_req && state_q == BCSR_SVC_IDLE) |=> (nv_wr_req && nv_wr_val == $past(svc_swap)))
        else $error("set-information call did not start a flag write");

    svc_write_end_a: assert property (@(posedge mclk) disable iff (!nrst)
        (nv_wr_req && nv_wr_ack) |=> (svc_done && !nv_wr_req) ##1 !svc_done)
        else $error("flag write did not finish with a single done pulse");

endmodule

`default_nettype wire

// ==== bcsr_remap.sv ====
/*
 * Boot cluster swap remap: sits between the CPU core and on-chip flash and
 * exchanges the two lowest 4 KB boot clusters when the latched swap is set.
 * Assumes nv_flag shows the stored boot flag from reset onward, and that the
 * CPU holds its first access until boot_ready goes high.
 */
`timescale 1ns/100ps
`default_nettype none

module bcsr_remap (
    input wire logic mclk,
    input wire logic nrst,
    input wire bcsr_pkg::bcsr_acc_t cpu_acc,
    output var bcsr_pkg::bcsr_acc_t mem_acc,
    input wire logic nv_flag,
    input wire logic svc_req,
    input wire logic svc_swap,
    input wire logic nv_wr_ack,
    output var logic nv_wr_req,
    output var logic nv_wr_val,
    output var logic svc_busy,
    output var logic svc_done,
    output var logic swap_active,
    output var logic boot_ready
);
    import bcsr_pkg::*;

    bcsr_boot_t boot_q;
    logic swap_q;
    logic ready_q;
    bcsr_acc_t acc_q;
    bcsr_acc_t acc_d;

    ////////////////////////////////////////////////////////////////////////////
    // boot sequencer: one load cycle after reset release, then run forever
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            boot_q <= BCSR_LOAD;
        end
        else
        begin
            unique case (boot_q)
                BCSR_LOAD:
                begin
                    boot_q <= BCSR_RUN;
                end
                BCSR_RUN:
                begin
                    boot_q <= BCSR_RUN;
                end
            endcase
        end
    end

    // swap latch: the stored flag is caught once after release, never later,
    // so a service call during run only takes effect at the next reset
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            swap_q <= SWAP_RST;
        end
        else if (boot_q == BCSR_LOAD)
        begin
            swap_q <= nv_flag;
        end
    end

    // ready rises together with the latched swap, so no access sees a stale map
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ready_q <= READY_RST;
        end
        else if (boot_q == BCSR_LOAD)
        begin
            ready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address path; fetches and data reads share it, so both see the same map
    always_comb
    begin
        acc_d = cpu_acc;
        acc_d.valid = cpu_acc.valid && (boot_q == BCSR_RUN);
        acc_d.addr = bcsr_remap_f(cpu_acc.addr, swap_q);
    end

    // one register stage keeps the flash address straight from a flop,
    // at the cost of one cycle of latency on every access
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_q <= '0;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // persistent flag programming through the set-information service
    bcsr_flag_svc u_svc (
        .mclk(mclk),
        .nrst(nrst),
        .svc_req(svc_req),
        .svc_swap(svc_swap),
        .nv_wr_ack(nv_wr_ack),
        .nv_wr_req(nv_wr_req),
        .nv_wr_val(nv_wr_val),
        .svc_busy(svc_busy),
        .svc_done(svc_done)
    );

    assign mem_acc = acc_q;
    assign swap_active = swap_q;
    assign boot_ready = ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // an access the remap takes this cycle
    logic run_acc;
    assign run_acc = cpu_acc.valid && (boot_q == BCSR_RUN);

    // swapped, cluster 0 addresses land in cluster 1
    swap_low_window_a: assert property (
        (run_acc && swap_q && cpu_acc.addr <= CLUSTER0_LAST)
        |=> (mem_acc.addr == $past(cpu_acc.addr) + CLUSTER1_BASE))
        else $error("swapped low cluster access not moved up 4 KB");

    // swapped, cluster 1 addresses land in cluster 0
    swap_high_window_a: assert property (
        (run_acc && swap_q && cpu_acc.addr >= CLUSTER1_BASE && cpu_acc.addr <= CLUSTER1_LAST)
        |=> (mem_acc.addr == $past(cpu_acc.addr) - CLUSTER1_BASE))
        else $error("swapped high cluster access not moved down 4 KB");

    // unswapped, cluster 0 stays in place
    plain_cluster0_a: assert property (
        (run_acc && !swap_q && cpu_acc.addr <= CLUSTER0_LAST)
        |=> (mem_acc.addr == $past(cpu_acc.addr) && mem_acc.valid))
        else $error("unswapped cluster 0 access was moved");

    // unswapped, cluster 1 stays in place
    plain_cluster1_a: assert property (
        (run_acc && !swap_q && cpu_acc.addr >= CLUSTER1_BASE && cpu_acc.addr <= CLUSTER1_LAST)
        |=> (mem_acc.addr == $past(cpu_acc.addr)))
        else $error("unswapped cluster 1 access was moved");

    // nothing above the window is touched, fetch or read
    upper_space_a: assert property (
        (run_acc && cpu_acc.addr >= SWAP_LIMIT)
        |=> (mem_acc.addr == $past(cpu_acc.addr) && mem_acc.is_fetch == $past(cpu_acc.is_fetch)))
        else $error("access above the swap window was altered");

    // the map is frozen for the whole run, whatever the service does
    swap_frozen_a: assert property (
        (boot_q == BCSR_RUN) [*2] |-> $stable(swap_active))
        else $error("swap state changed without a reset");

    // the stored flag is what the next boot uses
    flag_latched_a: assert property (
        (boot_q == BCSR_LOAD) |=> (swap_active == $past(nv_flag) && boot_ready))
        else $error("stored boot flag not applied after reset");

    // accesses pass with exactly one cycle of latency, none before ready
    acc_latency_a: assert property (
        mem_acc.valid |-> ($past(cpu_acc.valid) && $past(boot_ready)))
        else $error("flash access issued without a matching CPU access");

    // the load cycle drops whatever the core offers
    early_drop_a: assert property (
        !boot_ready |=> !mem_acc.valid)
        else $error("access passed before the boot map was latched");

    // once up, ready stays up until the next reset
    ready_hold_a: assert property (
        boot_ready |=> boot_ready)
        else $error("boot ready dropped without a reset");

    // the map that ready announces is the stored flag
    ready_map_a: assert property (
        $rose(boot_ready) |-> (swap_active == $past(nv_flag)))
        else $error("ready rose with a map other than the stored flag");

    // fetches and data reads are carried alike, one for one
    same_map_a: assert property (
        run_acc |=> (mem_acc.valid && mem_acc.is_fetch == $past(cpu_acc.is_fetch)))
        else $error("access dropped or its kind changed on the way to flash");

    // the exchange never leaves the two boot clusters
    window_kept_a: assert property (
        (run_acc && cpu_acc.addr < SWAP_LIMIT) |=> (mem_acc.addr < SWAP_LIMIT))
        else $error("boot cluster access left the swap window");

    // main scenarios: swapped and plain boot fetch, swapped data read, service calls
    cover_swapped_fetch_c: cover property (
        run_acc && swap_q && cpu_acc.is_fetch && cpu_acc.addr == CLUSTER0_BASE);
    cover_plain_fetch_c: cover property (
        run_acc && !swap_q && cpu_acc.is_fetch && cpu_acc.addr == CLUSTER0_BASE);
    cover_swapped_read_c: cover property (
        run_acc && swap_q && !cpu_acc.is_fetch && cpu_acc.addr >= CLUSTER1_BASE && cpu_acc.addr <= CLUSTER1_LAST);
    cover_service_c: cover property (
        svc_req ##[1:20] svc_done);
    cover_restore_c: cover property (
        svc_req && !svc_swap && swap_q);

endmodule

`default_nettype wire

// ==== bcsr_cpu_model.sv ====
/*
 * Far-side model: CPU core access driver plus the nonvolatile flag cell.
 * Assumes the bench drives req just after a rising edge of mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module bcsr_cpu_model (
    input wire logic mclk,
    input wire logic boot_ready,
    input wire bcsr_pkg::bcsr_acc_t req,
    input wire logic nv_wr_req,
    input wire logic nv_wr_val,
    input wire logic [3:0] ack_wait,
    output var bcsr_pkg::bcsr_acc_t cpu_acc,
    output var logic nv_wr_ack,
    output var logic nv_flag
);
    import bcsr_pkg::*;

    logic [3:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // the core holds every access until the boot map is latched
    always_comb
    begin
        cpu_acc = boot_ready ? req : '0;
    end

    // slow or prompt acknowledge, counted from the request
    always_ff @(posedge mclk)
    begin
        if (!nv_wr_req)
            cnt_q <= 4'h0;
        else if (cnt_q < ack_wait)
            cnt_q <= cnt_q + 4'h1;
    end

    assign nv_wr_ack = nv_wr_req && (cnt_q >= ack_wait);

    logic flag_q = 1'b0;

    // cell has no reset: it keeps its value across power loss
    always @(posedge mclk)
    begin
        if (nv_wr_req && nv_wr_ack)
            flag_q <= nv_wr_val;
    end

    assign nv_flag = flag_q;
endmodule

`default_nettype wire

// ==== bcsr_remap_tb_top.sv ====
/*
 * Self-checking bench for the boot cluster swap remap.
 * Assumes the design's outputs settle within 1 ns of a rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module bcsr_remap_tb_top;
    import bcsr_pkg::*;

    logic mclk, nrst, svc_req, svc_swap, nv_wr_ack, nv_wr_req, nv_wr_val;
    logic svc_busy, svc_done, swap_active, boot_ready, nv_flag;
    logic [3:0] ack_wait;
    bcsr_acc_t req, cpu_acc, mem_acc;
    int bad_count, checks_done, cycles;

    bcsr_cpu_model u_cpu (.mclk(mclk), .boot_ready(boot_ready), .req(req), .nv_wr_req(nv_wr_req),
        .nv_wr_val(nv_wr_val), .ack_wait(ack_wait), .cpu_acc(cpu_acc), .nv_wr_ack(nv_wr_ack),
        .nv_flag(nv_flag));

    bcsr_remap u_dut (.mclk(mclk), .nrst(nrst), .cpu_acc(cpu_acc), .mem_acc(mem_acc),
        .nv_flag(nv_flag), .svc_req(svc_req), .svc_swap(svc_swap), .nv_wr_ack(nv_wr_ack),
        .nv_wr_req(nv_wr_req), .nv_wr_val(nv_wr_val), .svc_busy(svc_busy), .svc_done(svc_done),
        .swap_active(swap_active), .boot_ready(boot_ready));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard: the whole run needs about 65 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset (also a power loss) and check the latched map
    task automatic do_reset(input logic exp_swap);
        @(posedge mclk);
        #1 nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("ready in reset", 18'h0, 18'(boot_ready));
        chk("mem in reset", 18'h0, mem_acc);
        nrst = 1'b1;
        @(posedge mclk);
        #1 chk("ready", 18'h1, 18'(boot_ready));
        chk("swap latched", 18'(exp_swap), 18'(swap_active));
        $display("reset test done");
    endtask

    // back-to-back fetches and reads across the cluster edges
    task automatic run_map(input logic sw);
        logic [15:0] tbl [7] = '{16'h0000, 16'h0fff, 16'h1000, 16'h1fff, 16'h2000, 16'h0abc, 16'hffff};
        logic [15:0] exp;
        for (int i = 0; i <= 7; i++)
        begin
            if (i > 0)
            begin
                exp = tbl[i-1];
                if (sw && exp < SWAP_LIMIT)
                    exp = (exp < CLUSTER1_BASE) ? exp + CLUSTER1_BASE : exp - CLUSTER1_BASE;
                chk("remap", {1'b1, ~i[0], exp}, mem_acc);
            end
            req = (i < 7) ? bcsr_acc_t'({1'b1, i[0], tbl[i]}) : '0;
            @(posedge mclk);
            #1;
        end
        chk("idle", 18'h0, 18'(mem_acc.valid));
        $display("map test done");
    endtask

    // set-information call; a call while busy must be ignored
    task automatic do_svc(input logic val, input logic [3:0] w, input logic cur);
        int n;
        ack_wait = w;
        svc_swap = val;
        svc_req = 1'b1;
        @(posedge mclk);
        #1;
        chk("wr_req", 18'h1, 18'(nv_wr_req));
        chk("wr_val", 18'(val), 18'(nv_wr_val));
        chk("busy", 18'h1, 18'(svc_busy));
        n = 0;
        if (w > 1)
        begin
            // call held into the busy time with the other value: must be refused
            svc_swap = ~val;
            @(posedge mclk);
            #1 n = 1;
        end
        svc_req = 1'b0;
        while (svc_done !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk("done wait", 18'(w + 4'h1), 18'(n));
        chk("busy after", 18'h0, 18'(svc_busy));
        chk("stored", 18'(val), 18'(nv_flag));
        chk("no early swap", 18'(cur), 18'(swap_active));
        @(posedge mclk);
        #1 chk("done pulse", 18'h0, 18'(svc_done));
        $display("service test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // new boot code is taken as written to cluster 1 before the swap call
    initial
    begin
        nrst = 1'b0;
        req = '0;
        svc_req = 1'b0;
        svc_swap = 1'b0;
        ack_wait = 4'h0;
        bad_count = 0;
        checks_done = 0;
        cycles = 0;
        do_reset(1'b0);
        run_map(1'b0);
        do_svc(1'b1, 4'h3, 1'b0);
        run_map(1'b0);
        do_reset(1'b1);
        run_map(1'b1);
        do_reset(1'b1);
        do_svc(1'b0, 4'h0, 1'b1);
        run_map(1'b1);
        do_reset(1'b0);
        run_map(1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
